/* hw/quad_deserializer.sv */
// Purpose: one 1:4 serial-to-parallel stage built from two converters
// Assumes: inValid is a one-cycle pulse per input item on the same clock
// Notes: the two converters keep separate phase counters; a mismatch is a fault
module quad_deserializer
  import sampler_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic syncRst_b,
  input wire logic reinit,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic [4*WIDTH-1:0] outWord,
  output logic outValid,
  output logic [1:0] phase,
  output logic alignFault
);

  // shift register, newest item enters at the top
  logic [4*WIDTH-1:0] shift_reg, shift_next;
  // phase counters of the low-half and high-half converters
  logic [1:0] phaseA_reg, phaseA_next;
  logic [1:0] phaseB_reg, phaseB_next;
  // captured word and its strobe
  logic [4*WIDTH-1:0] word_reg, word_next;
  logic valid_reg, valid_next;
  // sticky alignment fault
  logic fault_reg, fault_next;

  // next-state computation
  always_comb begin
    shift_next = shift_reg;
    phaseA_next = phaseA_reg;
    phaseB_next = phaseB_reg;
    word_next = word_reg;
    valid_next = 1'h0;
    // fault sticks once the converters disagree
    fault_next = fault_reg | (phaseA_reg != phaseB_reg);
    if (reinit) begin
      // realign both converters and drop the fault
      shift_next = '0;
      phaseA_next = PHASE_RESET;
      phaseB_next = PHASE_RESET;
      fault_next = 1'h0;
    end else if (inValid) begin
      // oldest item drifts toward lane 0
      shift_next = {inData, shift_reg[4*WIDTH-1:WIDTH]};
      phaseA_next = 2'(phaseA_reg + PHASE_STEP);
      phaseB_next = 2'(phaseB_reg + PHASE_STEP);
      if (phaseA_reg == PHASE_LAST) begin
        // fourth item completes the word
        word_next = shift_next;
        valid_next = 1'h1;
      end
    end
  end

  // registers
  always_ff @(posedge clk or negedge syncRst_b) begin
    if (!syncRst_b) begin
      shift_reg <= '0;
      phaseA_reg <= PHASE_RESET;
      phaseB_reg <= PHASE_RESET;
      word_reg <= '0;
      valid_reg <= 1'h0;
      fault_reg <= 1'h0;
    end else begin
      shift_reg <= shift_next;
      phaseA_reg <= phaseA_next;
      phaseB_reg <= phaseB_next;
      word_reg <= word_next;
      valid_reg <= valid_next;
      fault_reg <= fault_next;
    end
  end

  assign outWord = word_reg;
  assign outValid = valid_reg;
  assign phase = phaseA_reg;
  assign alignFault = fault_reg;

  // newest item lands in the top lane of a completed word
  newestLane_a: assert property (@(posedge clk) disable iff (!syncRst_b)
    (inValid && !reinit && phaseA_reg == PHASE_LAST) |=> outValid && outWord[4*WIDTH-1 -: WIDTH] == $past(inData))
    else $error("newest item not in top lane");

  // a converter disagreement raises the fault next cycle
  faultRaise_a: assert property (@(posedge clk) disable iff (!syncRst_b)
    (phaseA_reg != phaseB_reg && !reinit) |=> alignFault)
    else $error("alignment fault not raised");

  // words come out once every four accepted items
  wordSpacing_a: assert property (@(posedge clk) disable iff (!syncRst_b)
    (outValid) |-> phaseA_reg == PHASE_RESET)
    else $error("word strobe out of phase");

endmodule

/* hw/sampler_pkg.sv */
// Purpose: shared constants for the two-stage sample deserialiser
// Assumes: one 40 MHz clock; sample clock and pins arrive asynchronously
// Notes: sample codes, lane counts, counter widths and reset values live here
package sampler_pkg;

  // system clock period, for reference by the bench
  localparam int MCLK_PERIOD_NS = 25;

  // one sample is two bits carrying three levels
  localparam int SAMPLE_BITS = 2;
  // each deserialising stage gathers four inputs per word
  localparam int STAGE_LANES = 4;
  // final output width in samples and samples per cable
  localparam int OUT_SAMPLES = 16;
  localparam int CABLE_SAMPLES = 8;
  localparam int CABLE_BITS = CABLE_SAMPLES * SAMPLE_BITS;
  // stage word widths in bits
  localparam int STAGE_ONE_BITS = STAGE_LANES * SAMPLE_BITS;
  localparam int STAGE_TWO_BITS = OUT_SAMPLES * SAMPLE_BITS;

  // three-level codes: zero, positive outer, negative outer
  localparam logic [1:0] LEVEL_ZERO = 2'h0;
  localparam logic [1:0] LEVEL_POS = 2'h1;
  localparam logic [1:0] LEVEL_NEG = 2'h3;

  // converter phase counter: reset value and last lane
  localparam logic [1:0] PHASE_RESET = 2'h0;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] PHASE_STEP = 2'h1;

  // outer-level and cycle counters
  localparam int TALLY_BITS = 8;
  localparam int TALLY_MSB = 7;
  localparam logic [7:0] TALLY_RESET = 8'h00;
  localparam logic [7:0] TALLY_STEP = 8'h01;

  // feedback decision limits on the number of set counter msbs
  localparam logic [3:0] MSB_HIGH_LIMIT = 4'h5;
  localparam logic [3:0] MSB_LOW_LIMIT = 4'h3;

  // number of synchronised input pins
  localparam int PIN_COUNT = 7;

endpackage

/* hw/two_stage_sample_deserializer.sv */
// Purpose: back end of a two-bit three-level sampler: capture, 1:4 then 1:4 again
// Assumes: mclk is far faster than the sample clock, which is sampled as a pin
// Notes: outer-level tallies and a cycle tally feed a threshold feedback loop
module two_stage_sample_deserializer
  import sampler_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sampleClk,
  input wire logic compAbove,
  input wire logic compBelow,
  input wire logic stage_one_reinit,
  input wire logic stage_two_reinit,
  input wire logic tally_clear,
  input wire logic stage_two_clock_gate,
  output logic [STAGE_ONE_BITS-1:0] stageOneWord,
  output logic stageOneWordClk,
  output logic [CABLE_BITS-1:0] cableOneData,
  output logic [CABLE_BITS-1:0] cableTwoData,
  output logic cableOneClk,
  output logic cableTwoClk,
  output logic outer_level_tally_a_1,
  output logic outer_level_tally_a_2,
  output logic outer_level_tally_a_3,
  output logic outer_level_tally_a_4,
  output logic outer_level_tally_b_1,
  output logic outer_level_tally_b_2,
  output logic outer_level_tally_b_3,
  output logic outer_level_tally_b_4,
  output logic cycle_tally_msb,
  output logic stage_one_align_fault,
  output logic stage_two_align_fault,
  output logic thresholdRaise,
  output logic thresholdLower
);

  // three-level quantiser from the two comparator decisions
  function automatic logic [1:0] quantise(input logic above, input logic below);
    logic [1:0] code;
    code = LEVEL_ZERO;
    if (above && !below) begin
      code = LEVEL_POS;
    end else if (below && !above) begin
      code = LEVEL_NEG;
    end
    return code;
  endfunction

  // counter step with wraparound, like a ripple counter
  function automatic logic [TALLY_BITS-1:0] bump(input logic [TALLY_BITS-1:0] count, input logic hit);
    return hit ? TALLY_BITS'(count + TALLY_STEP) : count;
  endfunction

  // reset release synchroniser
  logic rstMeta_reg;
  logic syncRst_b;

  // pin synchronisers: two stages per pin
  logic [PIN_COUNT-1:0] pinMeta_reg;
  logic [PIN_COUNT-1:0] pinSync_reg;
  // previous synchronised sample clock, for edge finding
  logic sampleClkPrev_reg;

  // synchronised copies of the pins
  logic sampleClkSync;
  logic aboveSync;
  logic belowSync;
  logic reinitOneSync;
  logic reinitTwoSync;
  logic clearSync;
  logic gateSync;
  logic sampleRise;
  logic [1:0] sampleCode;

  // stage outputs
  logic [STAGE_ONE_BITS-1:0] s1Word;
  logic s1Valid;
  logic [1:0] s1Phase;
  logic s1Fault;
  logic [STAGE_TWO_BITS-1:0] s2Word;
  logic s2Valid;
  logic s2Fault;
  logic s2InValid;

  // output registers
  logic [CABLE_BITS-1:0] cableOne_reg, cableOne_next;
  logic [CABLE_BITS-1:0] cableTwo_reg, cableTwo_next;
  logic fwdClk_reg, fwdClk_next;

  // tallies: group a counts positive outer, group b negative outer
  logic [TALLY_BITS-1:0] tallyA_reg [STAGE_LANES];
  logic [TALLY_BITS-1:0] tallyA_next [STAGE_LANES];
  logic [TALLY_BITS-1:0] tallyB_reg [STAGE_LANES];
  logic [TALLY_BITS-1:0] tallyB_next [STAGE_LANES];
  logic [TALLY_BITS-1:0] cycle_reg, cycle_next;

  // feedback loop state
  logic cycleMsbPrev_reg, cycleMsbPrev_next;
  logic raise_reg, raise_next;
  logic lower_reg, lower_next;
  logic [3:0] msbCount;
  logic msbRise;

  // reset: asynchronous assert, two-flop release
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_reg <= 1'h0;
      syncRst_b <= 1'h0;
    end else begin
      rstMeta_reg <= 1'h1;
      syncRst_b <= rstMeta_reg;
    end
  end

  // all pins pass two flops before use
  always_ff @(posedge mclk or negedge syncRst_b) begin
    if (!syncRst_b) begin
      pinMeta_reg <= '0;
      pinSync_reg <= '0;
      sampleClkPrev_reg <= 1'h0;
    end else begin
      pinMeta_reg <= {stage_two_clock_gate, tally_clear, stage_two_reinit, stage_one_reinit,
                      compBelow, compAbove, sampleClk};
      pinSync_reg <= pinMeta_reg;
      sampleClkPrev_reg <= pinSync_reg[0];
    end
  end

  // unpack synchronised pins
  assign sampleClkSync = pinSync_reg[0];
  assign aboveSync = pinSync_reg[1];
  assign belowSync = pinSync_reg[2];
  assign reinitOneSync = pinSync_reg[3];
  assign reinitTwoSync = pinSync_reg[4];
  assign clearSync = pinSync_reg[5];
  assign gateSync = pinSync_reg[6];

  // one capture per rising sample clock edge
  assign sampleRise = sampleClkSync & ~sampleClkPrev_reg;
  assign sampleCode = quantise(aboveSync, belowSync);

  // first stage: serial samples into four-sample words
  quad_deserializer #(
    .WIDTH(SAMPLE_BITS)
  ) stageOne (
    .clk(mclk),
    .syncRst_b(syncRst_b),
    .reinit(reinitOneSync),
    .inValid(sampleRise),
    .inData(sampleCode),
    .outWord(s1Word),
    .outValid(s1Valid),
    .phase(s1Phase),
    .alignFault(s1Fault)
  );

  // second stage advances only while its clock gate is on
  assign s2InValid = s1Valid & gateSync;

  // second stage: four words into sixteen samples
  quad_deserializer #(
    .WIDTH(STAGE_ONE_BITS)
  ) stageTwo (
    .clk(mclk),
    .syncRst_b(syncRst_b),
    .reinit(reinitTwoSync),
    .inValid(s2InValid),
    .inData(s1Word),
    .outWord(s2Word),
    .outValid(s2Valid),
    .phase(),
    .alignFault(s2Fault)
  );

  // output word registers and forwarded clock
  always_comb begin
    cableOne_next = cableOne_reg;
    cableTwo_next = cableTwo_reg;
    fwdClk_next = fwdClk_reg;
    if (s2Valid) begin
      // low samples on cable one, high samples on cable two
      cableOne_next = s2Word[CABLE_BITS-1:0];
      cableTwo_next = s2Word[STAGE_TWO_BITS-1:CABLE_BITS];
      // one edge per word: clock at half the word rate
      fwdClk_next = ~fwdClk_reg;
    end
  end

  always_ff @(posedge mclk or negedge syncRst_b) begin
    if (!syncRst_b) begin
      cableOne_reg <= '0;
      cableTwo_reg <= '0;
      fwdClk_reg <= 1'h0;
    end else begin
      cableOne_reg <= cableOne_next;
      cableTwo_reg <= cableTwo_next;
      fwdClk_reg <= fwdClk_next;
    end
  end

  // outer-level tallies and cycle tally
  always_comb begin
    for (int i = 0; i < STAGE_LANES; i++) begin
      // count each lane of every stage-one word
      tallyA_next[i] = bump(tallyA_reg[i], s1Valid && s1Word[2*i +: 2] == LEVEL_POS);
      tallyB_next[i] = bump(tallyB_reg[i], s1Valid && s1Word[2*i +: 2] == LEVEL_NEG);
      if (clearSync) begin
        tallyA_next[i] = TALLY_RESET;
        tallyB_next[i] = TALLY_RESET;
      end
    end
    // one tick per word, cleared with the tallies
    cycle_next = clearSync ? TALLY_RESET : bump(cycle_reg, s1Valid);
  end

  always_ff @(posedge mclk or negedge syncRst_b) begin
    if (!syncRst_b) begin
      for (int i = 0; i < STAGE_LANES; i++) begin
        tallyA_reg[i] <= TALLY_RESET;
        tallyB_reg[i] <= TALLY_RESET;
      end
      cycle_reg <= TALLY_RESET;
    end else begin
      for (int i = 0; i < STAGE_LANES; i++) begin
        tallyA_reg[i] <= tallyA_next[i];
        tallyB_reg[i] <= tallyB_next[i];
      end
      cycle_reg <= cycle_next;
    end
  end

  // feedback: judge the tally msbs at each timebase msb rise
  assign msbRise = cycle_reg[TALLY_MSB] & ~cycleMsbPrev_reg;
  always_comb begin
    msbCount = 4'h0;
    for (int i = 0; i < STAGE_LANES; i++) begin
      msbCount = 4'(msbCount + {3'h0, tallyA_reg[i][TALLY_MSB]} + {3'h0, tallyB_reg[i][TALLY_MSB]});
    end
    cycleMsbPrev_next = cycle_reg[TALLY_MSB];
    raise_next = 1'h0;
    lower_next = 1'h0;
    if (msbRise) begin
      // too many outer samples: thresholds too low
      raise_next = msbCount > MSB_HIGH_LIMIT;
      // too few outer samples: thresholds too high
      lower_next = msbCount < MSB_LOW_LIMIT;
    end
  end

  always_ff @(posedge mclk or negedge syncRst_b) begin
    if (!syncRst_b) begin
      cycleMsbPrev_reg <= 1'h0;
      raise_reg <= 1'h0;
      lower_reg <= 1'h0;
    end else begin
      cycleMsbPrev_reg <= cycleMsbPrev_next;
      raise_reg <= raise_next;
      lower_reg <= lower_next;
    end
  end

  // outputs, each taken from a flop
  assign stageOneWord = s1Word;
  assign stageOneWordClk = s1Phase[1];
  assign cableOneData = cableOne_reg;
  assign cableTwoData = cableTwo_reg;
  assign cableOneClk = fwdClk_reg;
  assign cableTwoClk = fwdClk_reg;
  assign outer_level_tally_a_1 = tallyA_reg[0][TALLY_MSB];
  assign outer_level_tally_a_2 = tallyA_reg[1][TALLY_MSB];
  assign outer_level_tally_a_3 = tallyA_reg[2][TALLY_MSB];
  assign outer_level_tally_a_4 = tallyA_reg[3][TALLY_MSB];
  assign outer_level_tally_b_1 = tallyB_reg[0][TALLY_MSB];
  assign outer_level_tally_b_2 = tallyB_reg[1][TALLY_MSB];
  assign outer_level_tally_b_3 = tallyB_reg[2][TALLY_MSB];
  assign outer_level_tally_b_4 = tallyB_reg[3][TALLY_MSB];
  assign cycle_tally_msb = cycle_reg[TALLY_MSB];
  assign stage_one_align_fault = s1Fault;
  assign stage_two_align_fault = s2Fault;
  assign thresholdRaise = raise_reg;
  assign thresholdLower = lower_reg;

  // stage one reinit clears its fault
  oneFaultClear_a: assert property (@(posedge mclk) disable iff (!syncRst_b)
    reinitOneSync |=> !stage_one_align_fault)
    else $error("stage one fault survived reinit");

  // stage two reinit clears its own fault
  twoFaultClear_a: assert property (@(posedge mclk) disable iff (!syncRst_b)
    reinitTwoSync |=> !stage_two_align_fault)
    else $error("stage two fault survived reinit");

  // gate low stops stage two words
  gateStop_a: assert property (@(posedge mclk) disable iff (!syncRst_b)
    !gateSync |=> !s2Valid)
    else $error("stage two advanced with gate low");

  // forwarded clock flips exactly once per output word
  fwdToggle_a: assert property (@(posedge mclk) disable iff (!syncRst_b)
    s2Valid |=> cableOneClk != $past(cableOneClk) && cableOneData == $past(s2Word[CABLE_BITS-1:0]))
    else $error("forwarded clock or cable one wrong");

  // cable two carries the upper eight samples
  cableSplit_a: assert property (@(posedge mclk) disable iff (!syncRst_b)
    s2Valid |=> cableTwoData == $past(s2Word[STAGE_TWO_BITS-1:CABLE_BITS]))
    else $error("cable two data wrong");

  // tally clear empties group a lane zero, group b lane three and the cycle tally
  tallyClear_a: assert property (@(posedge mclk) disable iff (!syncRst_b)
    clearSync |=> tallyA_reg[0] == TALLY_RESET && tallyB_reg[3] == TALLY_RESET && cycle_reg == TALLY_RESET)
    else $error("tallies not cleared");

  // cycle tally advances once per word
  cycleStep_a: assert property (@(posedge mclk) disable iff (!syncRst_b)
    (s1Valid && !clearSync) |=> cycle_reg == TALLY_BITS'($past(cycle_reg) + TALLY_STEP))
    else $error("cycle tally did not advance");

  // a positive outer sample in lane zero counts in group a
  outerCount_a: assert property (@(posedge mclk) disable iff (!syncRst_b)
    (s1Valid && !clearSync && s1Word[1:0] == LEVEL_POS) |=>
      tallyA_reg[0] == TALLY_BITS'($past(tallyA_reg[0]) + TALLY_STEP))
    else $error("outer sample not counted");

  // too many set msbs raises the threshold next cycle
  feedbackRaise_a: assert property (@(posedge mclk) disable iff (!syncRst_b)
    (msbRise && msbCount > MSB_HIGH_LIMIT) |=> thresholdRaise && !thresholdLower)
    else $error("threshold raise missing");

endmodule

/* tb/correlator_model.sv */
// Purpose: receiving end of the two sample cables, as the correlator sees them
// Assumes: forwarded clock and cable data are launched on the same mclk edge
// Notes: captures on both clock edges; counts words and clock disagreement
module correlator_model
  import sampler_pkg::*;
(
  input wire logic mclk,
  input wire logic [CABLE_BITS-1:0] cableOneData,
  input wire logic [CABLE_BITS-1:0] cableTwoData,
  input wire logic cableOneClk,
  input wire logic cableTwoClk,
  output logic [STAGE_TWO_BITS-1:0] rxWord,
  output int rxCount,
  output int clkSkew
);
  timeunit 1ns;
  timeprecision 1ps;

  // last forwarded clock level seen
  logic lastClk = 1'b0;
  // received word, word count and clock disagreement count, all written by one process
  logic [STAGE_TWO_BITS-1:0] rxWord_reg = '0;
  int rxCount_reg = 0;
  int clkSkew_reg = 0;

  // outputs follow the single writer of each value
  assign rxWord = rxWord_reg;
  assign rxCount = rxCount_reg;
  assign clkSkew = clkSkew_reg;

  // any change of the forwarded clock marks a new word, rising or falling
  always @(posedge mclk) begin
    if (cableOneClk !== lastClk) begin
      // first cable carries samples 0-7, second 8-15
      rxWord_reg <= {cableTwoData, cableOneData};
      rxCount_reg <= rxCount_reg + 1;
    end
    // both cables must carry the very same clock
    if (cableOneClk !== cableTwoClk) begin
      clkSkew_reg <= clkSkew_reg + 1;
    end
    lastClk <= cableOneClk;
  end
endmodule

/* tb/testbench.sv */
// Purpose: self-checking bench for the two-stage sample deserialiser
// Assumes: sample pin at 200 ns, comparator levels set before each pin rise
// Notes: patterns hold only codes 00, 01 and 11; expectations come from them
module testbench import sampler_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // sixteen-sample test patterns, sample k at bits 2k+1:2k
  localparam logic [31:0] patOne = 32'h1D7C_F043;
  localparam logic [31:0] patTwo = 32'h4F31_D0C7;
  localparam logic [31:0] patThree = 32'hC3D1_7F40;
  localparam logic [31:0] patFour = 32'h0F5D_3C71;

  // design inputs, all defined from time zero
  logic mclk = 1'b0;
  // starts inactive so that asserting it at time zero is a real falling edge
  logic rst_b = 1'b1;
  logic sampleClk = 1'b0;
  logic compAbove = 1'b0;
  logic compBelow = 1'b0;
  logic stage_one_reinit = 1'b0;
  logic stage_two_reinit = 1'b0;
  logic tally_clear = 1'b0;
  logic stage_two_clock_gate = 1'b1;
  // design outputs
  logic [STAGE_ONE_BITS-1:0] stageOneWord;
  logic stageOneWordClk;
  logic [CABLE_BITS-1:0] cableOneData;
  logic [CABLE_BITS-1:0] cableTwoData;
  logic cableOneClk;
  logic cableTwoClk;
  logic tallyA1, tallyA2, tallyA3, tallyA4, tallyB1, tallyB2, tallyB3, tallyB4;
  logic cycle_tally_msb;
  logic stage_one_align_fault;
  logic stage_two_align_fault;
  logic thresholdRaise;
  logic thresholdLower;
  // what the correlator received
  logic [STAGE_TWO_BITS-1:0] rxWord;
  int rxCount;
  int clkSkew;
  // bench bookkeeping
  int errCount = 0;
  int checks = 0;
  int wordClkRises = 0;
  int raiseCount = 0;
  int lowerCount = 0;
  int mark;
  logic prevWordClk = 1'b0;
  logic [8:0] tallyBits;

  // all tally msbs, cycle tally on top
  assign tallyBits = {cycle_tally_msb, tallyB4, tallyB3, tallyB2, tallyB1, tallyA4, tallyA3, tallyA2, tallyA1};

  two_stage_sample_deserializer i_two_stage_sample_deserializer (
    .mclk(mclk),
    .rst_b(rst_b),
    .sampleClk(sampleClk),
    .compAbove(compAbove),
    .compBelow(compBelow),
    .stage_one_reinit(stage_one_reinit),
    .stage_two_reinit(stage_two_reinit),
    .tally_clear(tally_clear),
    .stage_two_clock_gate(stage_two_clock_gate),
    .stageOneWord(stageOneWord),
    .stageOneWordClk(stageOneWordClk),
    .cableOneData(cableOneData),
    .cableTwoData(cableTwoData),
    .cableOneClk(cableOneClk),
    .cableTwoClk(cableTwoClk),
    .outer_level_tally_a_1(tallyA1),
    .outer_level_tally_a_2(tallyA2),
    .outer_level_tally_a_3(tallyA3),
    .outer_level_tally_a_4(tallyA4),
    .outer_level_tally_b_1(tallyB1),
    .outer_level_tally_b_2(tallyB2),
    .outer_level_tally_b_3(tallyB3),
    .outer_level_tally_b_4(tallyB4),
    .cycle_tally_msb(cycle_tally_msb),
    .stage_one_align_fault(stage_one_align_fault),
    .stage_two_align_fault(stage_two_align_fault),
    .thresholdRaise(thresholdRaise),
    .thresholdLower(thresholdLower)
  );

  correlator_model i_correlator_model (
    .mclk(mclk),
    .cableOneData(cableOneData),
    .cableTwoData(cableTwoData),
    .cableOneClk(cableOneClk),
    .cableTwoClk(cableTwoClk),
    .rxWord(rxWord),
    .rxCount(rxCount),
    .clkSkew(clkSkew)
  );

  // 40 MHz system clock
  initial begin
    forever #(MCLK_PERIOD_NS / 2.0) mclk = ~mclk;
  end

  // word clock rises and feedback pulse cycles
  always @(posedge mclk) begin
    if (stageOneWordClk === 1'b1 && prevWordClk === 1'b0) begin
      wordClkRises <= wordClkRises + 1;
    end
    if (thresholdRaise === 1'b1) begin
      raiseCount <= raiseCount + 1;
    end
    if (thresholdLower === 1'b1) begin
      lowerCount <= lowerCount + 1;
    end
    prevWordClk <= stageOneWordClk;
  end

  // compare, count, report mismatch
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // wait a number of mclk rising edges
  task automatic cycles(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // one sample in 8 mclk: levels first, pin high 4 cycles, levels kept past the rise
  task automatic send_sample(input logic [1:0] code);
    @(posedge mclk);
    compAbove <= (code == LEVEL_POS);
    compBelow <= (code == LEVEL_NEG);
    cycles(3);
    sampleClk <= 1'b1;
    cycles(4);
    sampleClk <= 1'b0;
  endtask

  // sixteen samples in order, then time for both stages to settle
  task automatic send_pattern(input logic [31:0] pat);
    for (int k = 0; k < OUT_SAMPLES; k++) begin
      send_sample(pat[2*k +: 2]);
    end
    cycles(8);
  endtask

  // the same code on every lane for a number of stage-one words
  task automatic send_same(input logic [1:0] code, input int words);
    repeat (words * STAGE_LANES) send_sample(code);
  endtask

  // set one control level and give the synchroniser time
  task automatic hold_ctl(input int which, input logic level);
    case (which)
      0: stage_one_reinit <= level;
      1: stage_two_reinit <= level;
      2: tally_clear <= level;
      default: stage_two_clock_gate <= level;
    endcase
    cycles(6);
  endtask

  // verdict and end of run
  task automatic end_of_test;
    if (errCount == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // cut a hang short well past the expected run of about 13000 cycles
  initial begin
    cycles(40000);
    errCount++;
    end_of_test();
  end

  // main sequence
  initial begin
    // falling edge resets the design before the first clock edge
    rst_b <= 1'b0;
    cycles(8);
    check("word in reset", stageOneWord, '0);
    rst_b <= 1'b1;
    cycles(6);
    // plain sixteen-sample transfer
    mark = wordClkRises;
    send_pattern(patOne);
    check("stage one word", stageOneWord, patOne[31:24]);
    check("cable word", rxWord, patOne);
    check("words received", rxCount, 1);
    check("word clock rises", wordClkRises - mark, 4);
    check("cable clock skew", clkSkew, 0);
    // gate low: stage one runs, stage two holds
    hold_ctl(3, 1'b0);
    send_pattern(patTwo);
    check("ungated stage one", stageOneWord, patTwo[31:24]);
    check("gated cable word", rxWord, patOne);
    check("gated word count", rxCount, 1);
    hold_ctl(3, 1'b1);
    // half-built stage one word thrown away by reinit
    send_sample(LEVEL_POS);
    send_sample(LEVEL_NEG);
    hold_ctl(0, 1'b1);
    hold_ctl(0, 1'b0);
    send_pattern(patThree);
    check("stage one reinit", rxWord, patThree);
    // half-built stage two word thrown away by reinit
    repeat (8) send_sample(LEVEL_POS);
    hold_ctl(1, 1'b1);
    hold_ctl(1, 1'b0);
    send_pattern(patFour);
    check("stage two reinit", rxWord, patFour);
    check("word count", rxCount, 3);
    // tallies from a clean start
    hold_ctl(2, 1'b1);
    hold_ctl(2, 1'b0);
    check("tallies cleared", tallyBits, '0);
    mark = raiseCount;
    send_same(LEVEL_POS, 64);
    send_same(LEVEL_NEG, 64);
    cycles(8);
    check("msbs at 128 words", tallyBits, 9'h100);
    check("lower pulse", lowerCount, 1);
    send_same(LEVEL_POS, 64);
    send_same(LEVEL_NEG, 64);
    cycles(8);
    check("msbs at 256 words", tallyBits, 9'h0FF);
    send_same(LEVEL_ZERO, 128);
    cycles(8);
    check("msbs at 384 words", tallyBits, 9'h1FF);
    check("raise pulse", raiseCount - mark, 1);
    check("no second lower", lowerCount, 1);
    hold_ctl(2, 1'b1);
    hold_ctl(2, 1'b0);
    check("tallies cleared again", tallyBits, '0);
    // healthy converters never report a fault
    check("stage one fault", stage_one_align_fault, 0);
    check("stage two fault", stage_two_align_fault, 0);
    end_of_test();
  end
endmodule
